//--- hw/sdi_anc_builder.sv
`timescale 1ns/10ps
module sdi_anc_builder
  import sdi_anc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  sdi_anc_if.src           link,
  input  wire logic        cmd_valid_i,
  input  cmd_kind_t        cmd_kind_i,
  input  wire logic [7:0]  cmd_did_i,
  input  wire logic [7:0]  cmd_sdid_i,
  input  wire logic [7:0]  cmd_dc_i,
  input  wire logic [11:0] cmd_len_i,
  input  wire logic [9:0]  udw_i,
  output logic             udw_take_o,
  output logic             cmd_taken_o,
  output logic             busy_o
);

  typedef enum logic [3:0] {
    B_IDLE = 4'h0,
    B_F1   = 4'h1,
    B_F2   = 4'h2,
    B_F3   = 4'h3,
    B_DID  = 4'h4,
    B_SDID = 4'h5,
    B_DC   = 4'h6,
    B_PAY  = 4'h7,
    B_CS   = 4'h8,
    B_NC   = 4'h9
  } bstate_t;

  typedef enum logic [1:0] {
    A_DONE = 2'b00,
    A_NC   = 2'b01,
    A_DEL  = 2'b10
  } after_t;

  bstate_t          state_r;
  bstate_t          state_nxt;
  after_t           after_r;
  logic [7:0]       did_r;
  logic [7:0]       sdid_r;
  logic [7:0]       dc_r;
  logic [7:0]       cnt_r;
  logic [8:0]       sum_r;
  logic             user_r;
  logic [LEN_W-1:0] nc_left_r;
  logic [LEN_W-1:0] del_left_r;
  logic [9:0]       cur_word;
  logic [9:0]       nc_word;
  logic             take_cmd;
  logic             load_end;
  logic             load_del;
  logic [LEN_W-1:0] piece_src;
  logic [LEN_W-1:0] body;
  logic [7:0]       piece_dc;
  logic [LEN_W-1:0] piece_rem;
  logic             at_free;
  logic             nc_last;

  // points where a new command may follow without a gap
  assign at_free  = (state_r == B_IDLE) || (state_r == B_CS && after_r == A_DONE);
  assign nc_last  = (state_r == B_NC) && (nc_left_r <= 12'h001);
  assign take_cmd = cmd_valid_i && (at_free || (nc_last && cmd_kind_i == CMD_NC));
  assign load_end = (nc_last && !take_cmd)
                 || (state_r == B_CS && after_r == A_NC && nc_left_r == 12'h000);
  assign load_del = (state_r == B_CS) && (after_r == A_DEL);

  // deletion piece sizing: never leave a tail shorter than a packet
  always_comb begin
    piece_src = take_cmd ? cmd_len_i : del_left_r;
    body      = piece_src - LEN_OVH;
    if (body <= DC_MAX_L) begin
      piece_dc = body[7:0];
    end else if ((body - DC_MAX_L) >= LEN_OVH) begin
      piece_dc = DC_MAX;
    end else begin
      piece_dc = 8'(body - LEN_OVH);
    end
    piece_rem = body - {4'h0, piece_dc};
  end

  // non-conforming words are pulled out of the reserved ranges
  always_comb begin
    if (udw_i <= NC_LOW_MAX) begin
      nc_word = NC_LOW_SAFE;
    end else if (udw_i >= NC_HIGH_MIN) begin
      nc_word = NC_HIGH_SAFE;
    end else begin
      nc_word = udw_i;
    end
  end

  // word emitted for the current state
  always_comb begin
    case (state_r)
      B_F1:    cur_word = FLAG_ZERO;
      B_F2:    cur_word = FLAG_ONE;
      B_F3:    cur_word = FLAG_ONE;
      B_DID:   cur_word = hdr_word(did_r);
      B_SDID:  cur_word = hdr_word(sdid_r);
      B_DC:    cur_word = hdr_word(dc_r);
      B_PAY:   cur_word = user_r ? udw_i : DEL_FILL;
      B_CS:    cur_word = {~sum_r[8], sum_r};
      B_NC:    cur_word = nc_word;
      default: cur_word = FLAG_ZERO;
    endcase
  end

  // sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      B_IDLE:  state_nxt = take_cmd ? B_F1 : B_IDLE;
      B_F1:    state_nxt = B_F2;
      B_F2:    state_nxt = B_F3;
      B_F3:    state_nxt = B_DID;
      B_DID:   state_nxt = B_SDID;
      B_SDID:  state_nxt = B_DC;
      B_DC:    state_nxt = (dc_r == 8'h00) ? B_CS : B_PAY;
      B_PAY:   state_nxt = (cnt_r == 8'h01) ? B_CS : B_PAY;
      B_CS: begin
        if (after_r == A_NC && nc_left_r != 12'h000) begin
          state_nxt = B_NC;
        end else if (take_cmd || load_end || load_del) begin
          state_nxt = B_F1;
        end else begin
          state_nxt = B_IDLE;
        end
      end
      B_NC:    state_nxt = nc_last ? B_F1 : B_NC;
      default: state_nxt = B_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= B_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // packet set-up for commands, end markers and deletion pieces
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      did_r      <= 8'h00;
      sdid_r     <= 8'h00;
      dc_r       <= 8'h00;
      user_r     <= 1'b0;
      after_r    <= A_DONE;
      nc_left_r  <= 12'h000;
      del_left_r <= 12'h000;
    end else if (take_cmd && cmd_kind_i == CMD_NC) begin
      did_r     <= DID_START;
      sdid_r    <= 8'h00;
      dc_r      <= 8'h00;
      after_r   <= A_NC;
      nc_left_r <= cmd_len_i;
    end else if ((take_cmd && cmd_kind_i == CMD_DEL) || load_del) begin
      did_r      <= DID_DELETE;
      sdid_r     <= 8'h00;
      dc_r       <= piece_dc;
      user_r     <= 1'b0;
      del_left_r <= piece_rem;
      after_r    <= (piece_rem != 12'h000) ? A_DEL : A_DONE;
    end else if (take_cmd) begin
      did_r   <= cmd_did_i;
      sdid_r  <= cmd_sdid_i;
      dc_r    <= cmd_dc_i;
      user_r  <= 1'b1;
      after_r <= A_DONE;
    end else if (load_end) begin
      did_r   <= DID_END;
      sdid_r  <= 8'h00;
      dc_r    <= 8'h00;
      after_r <= A_DONE;
    end else if (state_r == B_NC) begin
      nc_left_r <= nc_left_r - 12'h001;
    end
  end

  // payload count and checksum
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= 8'h00;
      sum_r <= 9'h000;
    end else begin
      case (state_r)
        B_DID:  sum_r <= cur_word[8:0];
        B_SDID: sum_r <= sum_r + cur_word[8:0];
        B_DC: begin
          sum_r <= sum_r + cur_word[8:0];
          cnt_r <= dc_r;
        end
        B_PAY: begin
          sum_r <= sum_r + cur_word[8:0];
          cnt_r <= cnt_r - 8'h01;
        end
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // link and user-side outputs
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      link.word   <= 10'h000;
      link.valid  <= 1'b0;
      udw_take_o  <= 1'b0;
      cmd_taken_o <= 1'b0;
      busy_o      <= 1'b0;
    end else begin
      link.word   <= (state_r == B_IDLE) ? 10'h000 : cur_word;
      link.valid  <= (state_r != B_IDLE);
      udw_take_o  <= (state_nxt == B_PAY && user_r) || (state_nxt == B_NC);
      cmd_taken_o <= take_cmd;
      busy_o      <= (state_nxt != B_IDLE);
    end
  end

endmodule : sdi_anc_builder

//--- hw/sdi_anc_if.sv
`timescale 1ns/10ps
// word stream inside an ancillary space; valid high marks the space
interface sdi_anc_if;
  logic [9:0] word;
  logic       valid;
  modport src (output word, output valid);
  modport snk (input word, input valid);
endinterface : sdi_anc_if

//--- hw/sdi_anc_parser.sv
`timescale 1ns/10ps
module sdi_anc_parser
  import sdi_anc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  sdi_anc_if.snk           link,
  output pkt_type_t        type_o,
  output logic [14:0]      pkt_id_o,
  output logic [7:0]       dbn_o,
  output logic [7:0]       dc_o,
  output logic             hdr_done_o,
  output logic [9:0]       data_o,
  output logic             udw_valid_o,
  output logic             nc_valid_o,
  output logic             nc_active_o,
  output logic             pkt_end_o,
  output logic             start_marker_o,
  output logic             end_marker_o,
  output logic             space_empty_o,
  output logic             err_o
);

  typedef enum logic [3:0] {
    S_F1    = 4'h0,
    S_F2    = 4'h1,
    S_F3    = 4'h2,
    S_DID   = 4'h3,
    S_SDID  = 4'h4,
    S_DC    = 4'h5,
    S_UDW   = 4'h6,
    S_CS    = 4'h7,
    S_NC    = 4'h8,
    S_EMPTY = 4'h9
  } pstate_t;

  pstate_t     state_r;
  pstate_t     state_nxt;
  logic [9:0]  w;
  logic [7:0]  did_r;
  logic [7:0]  sdid_r;
  logic [7:0]  dc_r;
  logic [7:0]  cnt_r;
  logic [8:0]  sum_r;
  logic        bad_r;
  logic        is_start;
  logic        is_end;
  logic        cs_ok;
  pkt_type_t   type_nxt;

  assign w = link.word;

  // marker recognition from the finished header
  assign is_start = (did_r == DID_START) && (dc_r == 8'h00);
  assign is_end   = (did_r == DID_END) && (dc_r == 8'h00);

  // checksum word: low nine bits match the sum, bit 9 inverts bit 8
  assign cs_ok = (w[8:0] == sum_r) && (w[9] == ~w[8]);

  // type decode; zero DID overrides bit 7
  always_comb begin
    if (w[7:0] == DID_UNDEF) begin
      type_nxt = PT_UNDEF;
    end else if (w[7]) begin
      type_nxt = PT_TYPE1;
    end else begin
      type_nxt = PT_TYPE2;
    end
  end

  // word sequencing through flag, header, payload and checksum
  always_comb begin
    state_nxt = state_r;
    if (!link.valid) begin
      state_nxt = S_F1;
    end else begin
      case (state_r)
        S_F1: begin
          // a space must open with a flag
          state_nxt = (w == FLAG_ZERO) ? S_F2 : S_EMPTY;
        end
        S_F2: begin
          state_nxt = (w == FLAG_ONE) ? S_F3 : S_EMPTY;
        end
        S_F3: begin
          state_nxt = (w == FLAG_ONE) ? S_DID : S_EMPTY;
        end
        S_DID: begin
          state_nxt = S_SDID;
        end
        S_SDID: begin
          state_nxt = S_DC;
        end
        S_DC: begin
          state_nxt = (w[7:0] == 8'h00) ? S_CS : S_UDW;
        end
        S_UDW: begin
          state_nxt = (cnt_r == 8'h01) ? S_CS : S_UDW;
        end
        S_CS: begin
          if (is_start) begin
            state_nxt = S_NC;
          end else if (is_end) begin
            state_nxt = S_EMPTY;
          end else begin
            state_nxt = S_F1;
          end
        end
        S_NC: begin
          // a flag ends the region, whatever packet follows
          state_nxt = (w == FLAG_ZERO) ? S_F2 : S_NC;
        end
        S_EMPTY: begin
          state_nxt = S_EMPTY;
        end
        default: begin
          state_nxt = S_F1;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= S_F1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // header field capture and payload count
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      did_r  <= 8'h00;
      sdid_r <= 8'h00;
      dc_r   <= 8'h00;
      cnt_r  <= 8'h00;
    end else if (link.valid) begin
      case (state_r)
        S_DID:   did_r  <= w[7:0];
        S_SDID:  sdid_r <= w[7:0];
        S_DC: begin
          dc_r  <= w[7:0];
          cnt_r <= w[7:0];
        end
        S_UDW:   cnt_r  <= cnt_r - 8'h01;
        default: cnt_r  <= cnt_r;
      endcase
    end
  end

  // running checksum from DID through the last payload word
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sum_r <= 9'h000;
    end else if (link.valid) begin
      case (state_r)
        S_DID:                sum_r <= w[8:0];
        S_SDID, S_DC, S_UDW:  sum_r <= sum_r + w[8:0];
        default:              sum_r <= sum_r;
      endcase
    end
  end

  // header parity and complement check, held until the checksum
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bad_r <= 1'b0;
    end else if (link.valid) begin
      case (state_r)
        S_DID:        bad_r <= ~hdr_ok(w);
        S_SDID, S_DC: bad_r <= bad_r | ~hdr_ok(w);
        default:      bad_r <= bad_r;
      endcase
    end
  end

  // packet identity outputs
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      type_o   <= PT_UNDEF;
      pkt_id_o <= 15'h0000;
      dbn_o    <= 8'h00;
      dc_o     <= 8'h00;
    end else if (link.valid) begin
      if (state_r == S_DID) begin
        type_o <= type_nxt;
      end
      if (state_r == S_SDID) begin
        if (type_o == PT_TYPE2) begin
          pkt_id_o <= {did_r[6:0], w[7:0]};
          dbn_o    <= 8'h00;
        end else begin
          pkt_id_o <= {7'h00, did_r};
          dbn_o    <= w[7:0];
        end
      end
      if (state_r == S_DC) begin
        dc_o <= w[7:0];
      end
    end
  end

  // data words: payload and non-conforming words pass all ten bits
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      data_o      <= 10'h000;
      udw_valid_o <= 1'b0;
      nc_valid_o  <= 1'b0;
    end else begin
      udw_valid_o <= link.valid && (state_r == S_UDW);
      nc_valid_o  <= (state_nxt == S_NC) && (state_r == S_NC);
      if (link.valid && (state_r == S_UDW || state_r == S_NC)) begin
        data_o <= w;
      end
    end
  end

  // one-cycle event pulses and space levels
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hdr_done_o     <= 1'b0;
      pkt_end_o      <= 1'b0;
      start_marker_o <= 1'b0;
      end_marker_o   <= 1'b0;
      err_o          <= 1'b0;
      nc_active_o    <= 1'b0;
      space_empty_o  <= 1'b0;
    end else begin
      hdr_done_o     <= link.valid && (state_r == S_DC);
      pkt_end_o      <= link.valid && (state_r == S_CS);
      start_marker_o <= link.valid && (state_r == S_CS) && is_start;
      end_marker_o   <= link.valid && (state_r == S_CS) && is_end;
      err_o          <= link.valid && (state_r == S_CS) && (bad_r || !cs_ok);
      nc_active_o    <= (state_nxt == S_NC);
      space_empty_o  <= (state_nxt == S_EMPTY);
    end
  end

endmodule : sdi_anc_parser

//--- hw/sdi_anc_pkg.sv
package sdi_anc_pkg;

  // flag words and marker identifiers
  localparam logic [9:0]  FLAG_ZERO    = 10'h000;
  localparam logic [9:0]  FLAG_ONE     = 10'h3FF;
  localparam logic [7:0]  DID_UNDEF    = 8'h00;
  localparam logic [7:0]  DID_START    = 8'h88;
  localparam logic [7:0]  DID_END      = 8'h84;
  // deletion marking identifier; value is arbitrary
  localparam logic [7:0]  DID_DELETE   = 8'h80;
  localparam logic [9:0]  DEL_FILL     = 10'h200;

  // reserved ranges and their nearest legal values
  localparam logic [9:0]  NC_LOW_MAX   = 10'h003;
  localparam logic [9:0]  NC_HIGH_MIN  = 10'h3FC;
  localparam logic [9:0]  NC_LOW_SAFE  = 10'h004;
  localparam logic [9:0]  NC_HIGH_SAFE = 10'h3FB;

  // length arithmetic for command lengths
  localparam int unsigned LEN_W        = 12;
  localparam logic [11:0] LEN_OVH      = 12'h007;
  localparam logic [11:0] DC_MAX_L     = 12'h0FF;
  localparam logic [7:0]  DC_MAX       = 8'hFF;

  typedef enum logic [1:0] {
    PT_TYPE1 = 2'b00,
    PT_TYPE2 = 2'b01,
    PT_UNDEF = 2'b10
  } pkt_type_t;

  typedef enum logic [1:0] {
    CMD_PKT = 2'b00,
    CMD_NC  = 2'b01,
    CMD_DEL = 2'b10
  } cmd_kind_t;

  // header word: value, even parity in bit 8, its inverse in bit 9
  function automatic logic [9:0] hdr_word(input logic [7:0] v);
    logic p;
    p = ^v;
    return {~p, p, v};
  endfunction : hdr_word

  function automatic logic hdr_ok(input logic [9:0] w);
    return (w[8] == ^w[7:0]) && (w[9] == ~w[8]);
  endfunction : hdr_ok

endpackage : sdi_anc_pkg

//--- testbench/sdi_anc_properties.sv
`timescale 1ns/10ps
module sdi_anc_properties
  import sdi_anc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [9:0] word,
  input  wire logic       valid
);
  logic [8:0] pos_r;
  logic [8:0] sum_r;
  logic [7:0] did_r;
  logic [7:0] dc_r;
  logic       nc_r;
  logic       hdr_now;
  logic       cs_now;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // header word and checksum word slots on the wire
  assign hdr_now = valid && pos_r >= 9'h003 && pos_r <= 9'h005;
  assign cs_now  = valid && pos_r >= 9'h006 && pos_r == {1'b0, dc_r} + 9'h006;

  // position inside the packet and non-conforming region tracking
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !valid) begin
      pos_r <= 9'h000;
      nc_r  <= 1'b0;
    end else if (pos_r == 9'h000) begin
      if (word == FLAG_ZERO) begin
        pos_r <= 9'h001;
        nc_r  <= 1'b0;
      end
    end else if (cs_now) begin
      pos_r <= 9'h000;
      nc_r  <= (did_r == DID_START);
    end else begin
      pos_r <= pos_r + 9'h001;
    end
  end

  // header fields and running checksum
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      did_r <= 8'h00;
      dc_r  <= 8'h00;
      sum_r <= 9'h000;
    end else if (valid && pos_r == 9'h003) begin
      did_r <= word[7:0];
      sum_r <= word[8:0];
    end else if (valid && pos_r > 9'h003) begin
      sum_r <= sum_r + word[8:0];
      if (pos_r == 9'h005) begin
        dc_r <= word[7:0];
      end
    end
  end

  space_opens_a: assert property ($rose(valid) |-> word == FLAG_ZERO)
    else $error("space does not open with a flag");
  flag_ones_a: assert property (valid && pos_r == 9'h000 && word == FLAG_ZERO
    |=> valid && word == FLAG_ONE ##1 valid && word == FLAG_ONE)
    else $error("flag not followed by two all-ones words");
  hdr_parity_a: assert property (hdr_now
    |-> word[8] == ^word[7:0] && word[9] != word[8])
    else $error("header word parity or complement wrong");
  cs_sum_a: assert property (cs_now |-> word[8:0] == sum_r)
    else $error("checksum value wrong");
  cs_inv_a: assert property (cs_now |-> word[9] == ~word[8])
    else $error("checksum bit 9 not inverse of bit 8");
  pkt_whole_a: assert property (valid && pos_r != 9'h000 && !cs_now |=> valid)
    else $error("packet cut short by end of space");
  contig_a: assert property (cs_now && did_r != DID_START
    |=> !valid || word == FLAG_ZERO)
    else $error("packet not followed by a flag");
  nc_clean_a: assert property (valid && nc_r && word != FLAG_ZERO
    |-> word > NC_LOW_MAX && word < NC_HIGH_MIN)
    else $error("reserved value in non-conforming data");
  nc_closed_a: assert property (nc_r && valid |=> valid)
    else $error("non-conforming region left open");
  nc_marker_a: assert property (nc_r && valid && word == FLAG_ZERO
    |-> ##3 (word[7:0] == DID_END || word[7:0] == DID_START))
    else $error("non-conforming data not closed by a marker");
  marker_dc_a: assert property (valid && pos_r == 9'h003
    && (word[7:0] == DID_START || word[7:0] == DID_END) |-> ##2 word[7:0] == 8'h00)
    else $error("marker packet carries a payload");

  cover property (cs_now && did_r == DID_START);
  cover property (cs_now && did_r == DID_END);
  cover property (valid && nc_r && word != FLAG_ZERO);
endmodule : sdi_anc_properties

//--- testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import sdi_anc_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  cmd_kind_t   cmd_kind_i = CMD_PKT;
  logic [7:0]  cmd_did_i = 8'h00, cmd_sdid_i = 8'h00, cmd_dc_i = 8'h00;
  logic [11:0] cmd_len_i = 12'h000;
  logic [9:0]  udw_i = 10'h155;
  logic        udw_take_o, cmd_taken_o, busy_o, hdr_done_o, udw_valid_o, nc_valid_o;
  logic        nc_active_o, pkt_end_o, start_marker_o, end_marker_o, space_empty_o, err_o;
  pkt_type_t   type_o;
  logic [14:0] pkt_id_o;
  logic [7:0]  dbn_o, dc_o;
  logic [9:0]  data_o;
  logic        err2, end2, nc2, empty2;
  int          n_mismatch = 0, cmp_count = 0, del_mode = 0, del_words = 0;
  logic [9:0]  src_q[$];
  logic [11:0] dat_q[$];
  logic [32:0] hdr_q[$];
  logic [3:0]  end_q[$];
  logic        err2_q[$];

  sdi_anc_if link_bus();
  sdi_anc_if raw_bus();
  sdi_anc_builder sdi_anc_builder_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_bus.src),
    .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_did_i(cmd_did_i),
    .cmd_sdid_i(cmd_sdid_i), .cmd_dc_i(cmd_dc_i), .cmd_len_i(cmd_len_i), .udw_i(udw_i),
    .udw_take_o(udw_take_o), .cmd_taken_o(cmd_taken_o), .busy_o(busy_o));
  sdi_anc_parser sdi_anc_parser_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_bus.snk),
    .type_o(type_o), .pkt_id_o(pkt_id_o), .dbn_o(dbn_o), .dc_o(dc_o), .hdr_done_o(hdr_done_o),
    .data_o(data_o), .udw_valid_o(udw_valid_o), .nc_valid_o(nc_valid_o),
    .nc_active_o(nc_active_o), .pkt_end_o(pkt_end_o), .start_marker_o(start_marker_o),
    .end_marker_o(end_marker_o), .space_empty_o(space_empty_o), .err_o(err_o));
  sdi_anc_parser sdi_anc_parser_raw_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .link(raw_bus.snk), .type_o(), .pkt_id_o(), .dbn_o(), .dc_o(), .hdr_done_o(), .data_o(),
    .udw_valid_o(), .nc_valid_o(), .nc_active_o(nc2), .pkt_end_o(end2), .start_marker_o(),
    .end_marker_o(), .space_empty_o(empty2), .err_o(err2));
  sdi_anc_properties sdi_anc_properties_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .word(link_bus.word), .valid(link_bus.valid));

  // clock at 10 MHz
  always #50 clk_i = ~clk_i;

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic chk_hdr(input logic [32:0] got, input logic [32:0] exp);
    cmp(got, exp, "header");
  endtask : chk_hdr
  task automatic chk_dat(input logic [11:0] got, input logic [11:0] exp);
    cmp({21'h0, got}, {21'h0, exp}, "data word");
  endtask : chk_dat
  task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
    cmp({29'h0, got}, {29'h0, exp}, "status");
  endtask : chk_flag
  task automatic chk_cnt(input logic [11:0] got, input logic [11:0] exp);
    cmp({21'h0, got}, {21'h0, exp}, "count");
  endtask : chk_cnt

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic ran_out();
    n_mismatch++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask : ran_out

  function automatic logic [9:0] par(input logic [7:0] v);
    return {~(^v), ^v, v};
  endfunction : par

  // model of the parser results, compared as each result appears
  always @(posedge clk_i) begin
    if (del_mode != 0 && link_bus.valid === 1'b1) del_words++;
    if (hdr_done_o === 1'b1 && del_mode != 0)
      chk_hdr({type_o, pkt_id_o, 16'h0}, {PT_TYPE1, 7'h00, DID_DELETE, 16'h0});
    else if (hdr_done_o === 1'b1)
      chk_hdr({type_o, pkt_id_o, dbn_o, dc_o},
              hdr_q.size() ? hdr_q.pop_front() : 'x);
    if (udw_valid_o === 1'b1 || nc_valid_o === 1'b1)
      chk_dat({udw_valid_o, nc_valid_o, data_o},
              del_mode != 0 ? {2'b10, DEL_FILL} : dat_q.size() ? dat_q.pop_front() : 'x);
    // region level must stand while non-conforming words arrive
    if (nc_valid_o === 1'b1)
      chk_flag({3'b000, nc_active_o}, 4'h1);
    if (pkt_end_o === 1'b1)
      chk_flag({start_marker_o, end_marker_o, space_empty_o, err_o},
               del_mode != 0 ? 4'h0 : end_q.size() ? end_q.pop_front() : 'x);
    if (end2 === 1'b1)
      chk_flag({3'b000, err2},
               {3'b000, err2_q.size() ? err2_q.pop_front() : 1'bx});
  end

  // user data supply, advanced when the builder takes a word
  always @(posedge clk_i) begin
    if (udw_take_o === 1'b1 && src_q.size() > 0) void'(src_q.pop_front());
    #1 udw_i = (src_q.size() > 0) ? src_q[0] : 10'h155;
  end

  task automatic send_cmd(input cmd_kind_t k, input logic [7:0] did, sdid, dc,
                          input logic [11:0] len);
    int n;
    logic [9:0] w;
    pkt_type_t t;
    t = (did == 8'h00) ? PT_UNDEF : did[7] ? PT_TYPE1 : PT_TYPE2;
    if (k == CMD_PKT) begin
      hdr_q.push_back({t, (t == PT_TYPE2) ? {did[6:0], sdid} : {7'h00, did},
                       (t == PT_TYPE2) ? 8'h00 : sdid, dc});
      end_q.push_back(4'h0);
    end else if (k == CMD_NC) begin
      hdr_q.push_back({PT_TYPE1, 7'h00, DID_START, 16'h0000});
      end_q.push_back(4'h8);
    end
    for (int i = 0; i < ((k == CMD_PKT) ? int'(dc) : (k == CMD_NC) ? int'(len) : 0); i++) begin
      w = (k == CMD_NC && i < 4) ? (i[1] ? (i[0] ? 10'h3FC : 10'h003) : {10{i[0]}}) :
          10'($urandom);
      src_q.push_back(w);
      if (k == CMD_PKT) dat_q.push_back({2'b10, w});
      else dat_q.push_back({2'b01, w <= NC_LOW_MAX ? NC_LOW_SAFE : w >= NC_HIGH_MIN ?
                            NC_HIGH_SAFE : w});
    end
    cmd_kind_i = k;
    cmd_did_i = did;
    cmd_sdid_i = sdid;
    cmd_dc_i = dc;
    cmd_len_i = len;
    cmd_valid_i = 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (cmd_taken_o !== 1'b1 && n < 600);
    if (n >= 600) ran_out();
  endtask : send_cmd

  task automatic idle(input string name);
    int n;
    cmd_valid_i = 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while ((busy_o !== 1'b0 || link_bus.valid !== 1'b0) && n < 600);
    if (n >= 600) ran_out();
    repeat (3) @(posedge clk_i);
    #1 chk_cnt(12'(hdr_q.size() + dat_q.size() + end_q.size()), 12'h000);
    $display("test %s done", name);
  endtask : idle

  task automatic raw_put(input logic [9:0] w);
    @(posedge clk_i);
    #1 raw_bus.word = w;
    raw_bus.valid = 1'b1;
  endtask : raw_put

  // raw packet for the second parser, optionally broken on purpose
  task automatic raw_pkt(input logic [7:0] did, sdid, dc, input int fault);
    logic [8:0] s;
    logic [9:0] w;
    raw_put(FLAG_ZERO);
    raw_put(FLAG_ONE);
    raw_put(FLAG_ONE);
    s = 9'h000;
    for (int i = 0; i < int'(dc) + 3; i++) begin
      w = (i == 0) ? par(did) : (i == 1) ? par(sdid) : (i == 2) ? par(dc) : 10'($urandom);
      if (fault == 3 && i == 2) w[9] = ~w[9];
      s = s + w[8:0];
      raw_put(w);
    end
    w = {~s[8], s} ^ {fault == 2, 8'h00, fault == 1};
    raw_put(w);
    err2_q.push_back(fault != 0);
  endtask : raw_pkt

  initial begin
    raw_bus.word = 10'h000;
    raw_bus.valid = 1'b0;
    void'($urandom(32'h8987));
    repeat (20) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    // back-to-back packets of every type, empty and full payload
    send_cmd(CMD_PKT, 8'h00, 8'h05, 8'h03, 12'h000);
    send_cmd(CMD_PKT, 8'hC5, 8'h00, 8'h00, 12'h000);
    send_cmd(CMD_PKT, 8'h41, 8'($urandom), 8'hFF, 12'h000);
    send_cmd(CMD_PKT, 8'h81, 8'hFF, 8'h01, 12'h000);
    idle("packets");
    // non-conforming region, then two regions back to back
    send_cmd(CMD_NC, 8'h00, 8'h00, 8'h00, 12'h006);
    hdr_q.push_back({PT_TYPE1, 7'h00, DID_END, 16'h0000});
    end_q.push_back(4'h6);
    idle("nc single");
    send_cmd(CMD_NC, 8'h00, 8'h00, 8'h00, 12'h004);
    send_cmd(CMD_NC, 8'h00, 8'h00, 8'h00, 12'h001);
    hdr_q.push_back({PT_TYPE1, 7'h00, DID_END, 16'h0000});
    end_q.push_back(4'h6);
    idle("nc pair");
    // deletion spans of minimum and longer length
    for (int j = 0; j < 2; j++) begin
      del_mode = 1;
      del_words = 0;
      send_cmd(CMD_DEL, 8'h00, 8'h00, 8'h00, j ? 12'h014 : 12'h007);
      idle("delete");
      chk_cnt(12'(del_words), j ? 12'h014 : 12'h007);
      del_mode = 0;
    end
    // faulty packets into the second parser, then no flag after a checksum
    raw_pkt(8'h41, 8'h23, 8'h02, 0);
    for (int f = 1; f < 4; f++) raw_pkt(8'hA1, 8'h01, 8'h01, f);
    raw_put(10'h155);
    @(posedge clk_i);
    #1 chk_flag({3'b000, empty2}, 4'h1);
    raw_bus.valid = 1'b0;
    raw_bus.word = 10'h2AA;
    // start marker region closed by a plain packet
    raw_pkt(DID_START, 8'h00, 8'h00, 0);
    raw_put(10'h2AA);
    raw_put(10'h155);
    @(posedge clk_i);
    #1 chk_flag({3'b000, nc2}, 4'h1);
    raw_pkt(8'hC2, 8'h00, 8'h01, 0);
    @(posedge clk_i);
    #1 chk_flag({3'b000, nc2}, 4'h0);
    raw_bus.valid = 1'b0;
    raw_bus.word = 10'h155;
    repeat (3) @(posedge clk_i);
    $display("test raw done");
    give_verdict();
  end
endmodule : testbench
